// ===== src/cfrs_pkg.sv
// Constants and types for the CCD frame readout sequencer
package cfrs_pkg;
   // Frame geometry, rows
   localparam logic [10:0] ROWS_LEAD_DARK = 11'd2;
   localparam logic [10:0] ROWS_PHOTO = 11'd1208;
   localparam logic [10:0] ROWS_TRAIL_DARK = 11'd4;
   localparam logic [10:0] ROWS_BUFFER = 11'd4;
   localparam logic [10:0] ROWS_IMAGE = 11'd1200;
   localparam logic [10:0] ROWS_TOTAL = 11'(ROWS_LEAD_DARK + ROWS_PHOTO + ROWS_TRAIL_DARK);
   localparam logic [10:0] ROW_LAST = 11'(ROWS_TOTAL - 11'd1);
   localparam logic [10:0] ROW_PHOTO_FIRST = ROWS_LEAD_DARK;
   localparam logic [10:0] ROW_PHOTO_END = 11'(ROWS_LEAD_DARK + ROWS_PHOTO);
   localparam logic [10:0] ROW_IMG_FIRST = 11'(ROWS_LEAD_DARK + ROWS_BUFFER);
   localparam logic [10:0] ROW_IMG_END = 11'(ROW_IMG_FIRST + ROWS_IMAGE);
   // Line geometry, pixels
   localparam logic [10:0] PIX_EMPTY = 11'd4;
   localparam logic [10:0] PIX_DARK = 11'd16;
   localparam logic [10:0] PIX_PHOTO_SINGLE = 11'd1608;
   localparam logic [10:0] PIX_PHOTO_DUAL = 11'd804;
   localparam logic [10:0] PIX_BUFFER = 11'd4;
   localparam logic [10:0] PIX_IMAGE_SINGLE = 11'd1600;
   localparam logic [10:0] PIX_IMAGE_DUAL = 11'd800;
   localparam logic [10:0] HREG_CELLS = 11'd1648;
   localparam logic [10:0] HREG_HALF = 11'd824;
   localparam logic [10:0] PIX_LINE_SINGLE = 11'(PIX_EMPTY + PIX_DARK + PIX_PHOTO_SINGLE + PIX_DARK);
   localparam logic [10:0] PIX_LINE_DUAL = 11'(PIX_EMPTY + PIX_DARK + PIX_PHOTO_DUAL);
   localparam logic [10:0] PIX_IMG_FIRST = 11'(PIX_EMPTY + PIX_DARK + PIX_BUFFER);
   localparam logic [10:0] PIX_IMG_END_SINGLE = 11'(PIX_IMG_FIRST + PIX_IMAGE_SINGLE);
   localparam logic [10:0] PIX_IMG_END_DUAL = 11'(PIX_IMG_FIRST + PIX_IMAGE_DUAL);
   localparam logic [10:0] PIX_RIGHT_BASE = 11'(PIX_IMG_END_SINGLE - 11'd1);
   localparam logic [10:0] PIX_DARKL_FIRST = 11'(PIX_EMPTY + 11'd1);
   localparam logic [10:0] PIX_DARKL_END = 11'(PIX_EMPTY + PIX_DARK - 11'd1);
   localparam logic [10:0] PIX_DARKR_FIRST = 11'(PIX_EMPTY + PIX_DARK + PIX_PHOTO_SINGLE + 11'd1);
   localparam logic [10:0] PIX_DARKR_END = 11'(PIX_LINE_SINGLE - 11'd1);
   // Timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int T_VPULSE_NS = 2000;
   localparam int T_HD_NS = 1000;
   localparam int PIX_RATE_FAST_MHZ = 40;
   localparam int PIX_RATE_SLOW_MHZ = 20;
   localparam logic [11:0] VPULSE_CYC = 12'((T_VPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] VXFER_CYC = 12'(2 * VPULSE_CYC);
   localparam logic [11:0] HD_CYC = 12'((T_HD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] PIX_CYC_FAST = 4'(1000 / (PIX_RATE_FAST_MHZ * CLK_PERIOD_NS));
   localparam logic [3:0] PIX_CYC_SLOW = 4'(1000 / (PIX_RATE_SLOW_MHZ * CLK_PERIOD_NS));
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_VXFER = 2'b01,
      S_VHOLD = 2'b10,
      S_HSHIFT = 2'b11
   } cfrs_state_t;
endpackage

// ===== src/cfrs_pix_if.sv
// Pixel timing link between sequencer and pixel timer
`timescale 1ns/1ps
`default_nettype none
interface cfrs_pix_if;
   logic run;
   logic slow;
   logic h_one;
   logic sample;
   logic reset_pulse;
   logic pix_end;
   modport timer (input run, input slow, output h_one, output sample, output reset_pulse, output pix_end);
   modport seq (output run, output slow, input h_one, input sample, input reset_pulse, input pix_end);
endinterface
`default_nettype wire

// ===== src/cfrs_pix_timer.sv
// Per-pixel horizontal phase, sample and reset gate timer
`timescale 1ns/1ps
`default_nettype none
module cfrs_pix_timer
   import cfrs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   cfrs_pix_if.timer pif
);
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic [3:0] period;
   logic h_one_r;
   logic sample_r;
   logic reset_r;

   assign period = pif.slow ? PIX_CYC_SLOW : PIX_CYC_FAST;
   assign pif.pix_end = pif.run && (cnt_r == 4'(period - 4'h1));
   assign pif.h_one = h_one_r;
   assign pif.sample = sample_r;
   assign pif.reset_pulse = reset_r;

   always_comb begin
      if (!pif.run || pif.pix_end) begin
         cnt_nxt = 4'h0;
      end else begin
         cnt_nxt = 4'(cnt_r + 4'h1);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 4'h0;
      end else if (clk_en) begin
         cnt_r <= cnt_nxt;
      end
   end

   // Phase one idles high; each pixel is low for the first period/2 cycles (rounded down), then high; the first pixel of a line is low one cycle less
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         h_one_r <= 1'b1;
      end else if (clk_en) begin
         h_one_r <= !pif.run || (cnt_nxt >= (period >> 1));
      end
   end

   // Sample near pixel end, then reset gate in the final cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sample_r <= 1'b0;
         reset_r <= 1'b0;
      end else if (clk_en) begin
         sample_r <= pif.run && (cnt_nxt == 4'(period - 4'h2));
         reset_r <= pif.run && (cnt_nxt == 4'(period - 4'h1));
      end
   end
endmodule
`default_nettype wire

// ===== src/cfrs_readout_seq.sv
// CCD frame readout sequencer: vertical, horizontal and qualifier timing
`timescale 1ns/1ps
`default_nettype none
module cfrs_readout_seq
   import cfrs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic frame_start,
   input wire logic dual_mode,
   input wire logic full_range_slow,
   input wire logic discard_line,
   output logic vertical_phase_one,
   output logic vertical_phase_two,
   output logic line_discard_gate,
   output logic left_storage_phase_one,
   output logic left_storage_phase_two,
   output logic left_barrier_phase_one,
   output logic left_barrier_phase_two,
   output logic right_storage_phase_one,
   output logic right_storage_phase_two,
   output logic right_barrier_phase_one,
   output logic right_barrier_phase_two,
   output logic reset_gate_left,
   output logic reset_gate_right,
   output logic sample_strobe,
   output logic image_valid,
   output logic dark_ref_valid,
   output logic [10:0] row_index,
   output logic [10:0] pixel_index,
   output logic [10:0] image_col_left,
   output logic [10:0] image_col_right,
   output logic frame_busy,
   output logic frame_done
);
   cfrs_pix_if pif();
   cfrs_state_t state_r;
   cfrs_state_t state_nxt;
   logic [11:0] cnt_r;
   logic [10:0] row_r;
   logic [10:0] pix_r;
   logic [10:0] pix_last;
   logic dual_r;
   logic slow_r;
   logic discard_r;
   logic line_end;
   logic last_row;
   logic row_img;
   logic row_photo;
   logic pix_img;
   logic pix_dark;
   logic h1;
   logic v_one_r;
   logic v_two_r;
   logic discard_gate_r;
   logic h1_r;
   logic rb_one_r;
   logic rb_two_r;
   logic rg_left_r;
   logic rg_right_r;
   logic sample_r;
   logic img_r;
   logic dark_r;
   logic [10:0] row_out_r;
   logic [10:0] pix_out_r;
   logic [10:0] col_left_r;
   logic [10:0] col_right_r;
   logic busy_r;
   logic done_r;

   cfrs_pix_timer u_timer (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .pif(pif.timer)
   );

   assign pif.run = (state_r == S_HSHIFT);
   assign pif.slow = slow_r;
   assign pix_last = dual_r ? 11'(PIX_LINE_DUAL - 11'd1) : 11'(PIX_LINE_SINGLE - 11'd1);
   assign last_row = (row_r == ROW_LAST);

   // Line sequence: transfer, hold-off, horizontal shift
   always_comb begin
      state_nxt = state_r;
      line_end = 1'b0;
      case (state_r)
         S_IDLE: begin
            if (frame_start) begin
               state_nxt = S_VXFER;
            end
         end
         S_VXFER: begin
            if (cnt_r == 12'(VXFER_CYC - 12'h1)) begin
               state_nxt = S_VHOLD;
            end
         end
         S_VHOLD: begin
            if (cnt_r == 12'(HD_CYC - 12'h1)) begin
               if (discard_r) begin
                  line_end = 1'b1;
                  state_nxt = last_row ? S_IDLE : S_VXFER;
               end else begin
                  state_nxt = S_HSHIFT;
               end
            end
         end
         S_HSHIFT: begin
            if (pif.pix_end && (pix_r == pix_last)) begin
               line_end = 1'b1;
               state_nxt = last_row ? S_IDLE : S_VXFER;
            end
         end
         default: begin
            state_nxt = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= S_IDLE;
      end else if (clk_en) begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 12'h0;
      end else if (clk_en) begin
         if (state_nxt != state_r) begin
            cnt_r <= 12'h0;
         end else begin
            cnt_r <= 12'(cnt_r + 12'h1);
         end
      end
   end

   // Mode and rate are static for a whole frame
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dual_r <= 1'b0;
         slow_r <= 1'b0;
      end else if (clk_en && (state_r == S_IDLE) && frame_start) begin
         dual_r <= dual_mode;
         slow_r <= full_range_slow;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         discard_r <= 1'b0;
      end else if (clk_en && (state_nxt == S_VXFER) && (state_r != S_VXFER)) begin
         discard_r <= discard_line;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         row_r <= 11'h0;
      end else if (clk_en) begin
         if (state_r == S_IDLE) begin
            row_r <= 11'h0;
         end else if (line_end) begin
            row_r <= 11'(row_r + 11'd1);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pix_r <= 11'h0;
      end else if (clk_en) begin
         if (state_r != S_HSHIFT) begin
            pix_r <= 11'h0;
         end else if (pif.pix_end) begin
            pix_r <= 11'(pix_r + 11'd1);
         end
      end
   end

   // Vertical pair: phase one then phase two, never while shifting
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         v_one_r <= 1'b0;
         v_two_r <= 1'b0;
         discard_gate_r <= 1'b0;
      end else if (clk_en) begin
         v_one_r <= (state_r == S_VXFER) && (cnt_r < VPULSE_CYC);
         v_two_r <= (state_r == S_VXFER) && (cnt_r >= VPULSE_CYC);
         discard_gate_r <= (state_r == S_VXFER) && discard_r;
      end
   end

   // All horizontal gates switch on the same edge
   // Parked high outside shifting, so the last pixel leaves no low glitch
   assign h1 = pif.h_one || (state_r != S_HSHIFT);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         h1_r <= 1'b1;
         rb_one_r <= 1'b0;
         rb_two_r <= 1'b1;
      end else if (clk_en) begin
         h1_r <= h1;
         rb_one_r <= dual_r ? h1 : !h1;
         rb_two_r <= dual_r ? !h1 : h1;
      end
   end

   // Pixel qualifiers
   assign row_img = (row_r >= ROW_IMG_FIRST) && (row_r < ROW_IMG_END);
   assign row_photo = (row_r >= ROW_PHOTO_FIRST) && (row_r < ROW_PHOTO_END);
   assign pix_img = (pix_r >= PIX_IMG_FIRST) && (pix_r < (dual_r ? PIX_IMG_END_DUAL : PIX_IMG_END_SINGLE));
   assign pix_dark = ((pix_r >= PIX_DARKL_FIRST) && (pix_r < PIX_DARKL_END)) ||
                     (!dual_r && (pix_r >= PIX_DARKR_FIRST) && (pix_r < PIX_DARKR_END));

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sample_r <= 1'b0;
         img_r <= 1'b0;
         dark_r <= 1'b0;
         rg_left_r <= 1'b0;
         rg_right_r <= 1'b0;
      end else if (clk_en) begin
         sample_r <= pif.sample;
         img_r <= pif.sample && row_img && pix_img;
         dark_r <= pif.sample && row_photo && pix_dark;
         rg_left_r <= pif.reset_pulse;
         rg_right_r <= pif.reset_pulse && dual_r;
      end
   end

   // Line buffer columns: right output lands mirrored after the left half
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         row_out_r <= 11'h0;
         pix_out_r <= 11'h0;
         col_left_r <= 11'h0;
         col_right_r <= 11'h0;
      end else if (clk_en && pif.sample) begin
         row_out_r <= row_r;
         pix_out_r <= pix_r;
         col_left_r <= 11'(pix_r - PIX_IMG_FIRST);
         col_right_r <= 11'(PIX_RIGHT_BASE - pix_r);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else if (clk_en) begin
         busy_r <= (state_nxt != S_IDLE);
         done_r <= line_end && last_row;
      end
   end

   assign vertical_phase_one = v_one_r;
   assign vertical_phase_two = v_two_r;
   assign line_discard_gate = discard_gate_r;
   assign left_storage_phase_one = h1_r;
   assign left_storage_phase_two = !h1_r;
   assign left_barrier_phase_one = h1_r;
   assign left_barrier_phase_two = !h1_r;
   assign right_storage_phase_one = h1_r;
   assign right_storage_phase_two = !h1_r;
   assign right_barrier_phase_one = rb_one_r;
   assign right_barrier_phase_two = rb_two_r;
   assign reset_gate_left = rg_left_r;
   assign reset_gate_right = rg_right_r;
   assign sample_strobe = sample_r;
   assign image_valid = img_r;
   assign dark_ref_valid = dark_r;
   assign row_index = row_out_r;
   assign pixel_index = pix_out_r;
   assign image_col_left = col_left_r;
   assign image_col_right = col_right_r;
   assign frame_busy = busy_r;
   assign frame_done = done_r;

   // Cycles since vertical phase two fell, for hold-off checking
   logic v_two_d_r;
   logic [11:0] since_v_r;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         v_two_d_r <= 1'b0;
         since_v_r <= 12'h0;
      end else if (clk_en) begin
         v_two_d_r <= v_two_r;
         if (v_two_d_r && !v_two_r) begin
            since_v_r <= 12'h1;
         end else if (since_v_r != 12'hfff) begin
            since_v_r <= 12'(since_v_r + 12'h1);
         end
      end
   end

   sequence seq_sample;
      clk_en && sample_strobe;
   endsequence
   sequence seq_reset_next;
      ##1 reset_gate_left;
   endsequence

   a_frame_rows: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && line_end && row_r == 11'd1213) |=> (state_r == S_IDLE) && frame_done)
      else $error("frame did not end after last row");
   a_image_rows: assert property (@(posedge clk_sys) disable iff (!rst_n)
      image_valid |-> (row_index >= 11'd6) && (row_index < 11'd1206))
      else $error("image flag outside image rows");
   a_image_cols: assert property (@(posedge clk_sys) disable iff (!rst_n)
      image_valid |-> (pixel_index >= 11'd24) && (pixel_index < 11'd1624))
      else $error("image flag outside image columns");
   a_dark_centre: assert property (@(posedge clk_sys) disable iff (!rst_n)
      dark_ref_valid |-> ((pixel_index >= 11'd5) && (pixel_index <= 11'd18)) ||
                         ((pixel_index >= 11'd1629) && (pixel_index <= 11'd1642)))
      else $error("dark reference outside centre columns");
   a_single_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && pif.pix_end && !dual_r) |-> (pix_r <= 11'd1643))
      else $error("single line exceeded 1644 pixels");
   a_dual_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && pif.pix_end && dual_r && pix_r == 11'd823) |=> (state_r != S_HSHIFT))
      else $error("dual line did not end at 824 pixels");
   a_hstop_vxfer: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_r == S_VXFER) |-> left_storage_phase_one && !left_storage_phase_two)
      else $error("horizontal clocks not parked during vertical shift");
   a_hold_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_r == S_HSHIFT && $past(state_r) == S_VHOLD) |-> (since_v_r >= 12'd199))
      else $error("horizontal restart before transfer delay");
   a_quiet_shift: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_r == S_HSHIFT) |-> !vertical_phase_one && !vertical_phase_two && !line_discard_gate)
      else $error("vertical or discard pulse during shifting");
   a_barrier_swap: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (dual_r && $stable(dual_r)) |-> (right_barrier_phase_one == left_barrier_phase_one))
      else $error("dual mode right barrier not on phase one");
   a_barrier_single: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!dual_r && $stable(dual_r)) |-> (right_barrier_phase_two == left_barrier_phase_one))
      else $error("single mode right barrier not on phase one");
   a_reset_after: assert property (@(posedge clk_sys) disable iff (!rst_n)
      seq_sample |-> seq_reset_next)
      else $error("no reset gate after sample");
   a_discard_line: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && state_r == S_VHOLD && discard_r) |=> (state_r != S_HSHIFT))
      else $error("discarded line was shifted out");
endmodule
`default_nettype wire

// ===== tb/cfrs_sensor_model.sv
// Behavioural sensor model: counts transferred rows and horizontal clocks
`timescale 1ns/1ps
`default_nettype none
module cfrs_sensor_model (
   input wire logic rst_n,
   input wire logic vertical_phase_one,
   input wire logic vertical_phase_two,
   input wire logic line_discard_gate,
   input wire logic left_storage_phase_one,
   output var int rows_loaded,
   output var int rows_dumped,
   output var int hclk_last
);
   localparam int FRAME_ROWS = 2 + 1208 + 4;
   int hclk_cur;
   int hclk_base;
   logic dump_now;
   // Each phase-one rise moves every packet one cell toward the output
   always @(negedge rst_n or posedge left_storage_phase_one) begin
      if (!rst_n)
         hclk_cur = 0;
      else
         hclk_cur++;
   end
   // A new transfer closes the pixel count of the line before
   always @(negedge rst_n or posedge vertical_phase_one) begin
      if (!rst_n) begin
         hclk_last = 0;
         hclk_base = 0;
      end else begin
         hclk_last = hclk_cur - hclk_base;
         hclk_base = hclk_cur;
      end
   end
   // Gate level mid-transfer decides between loading and dumping
   always @(posedge vertical_phase_two) begin
      dump_now = line_discard_gate;
   end
   always @(negedge rst_n or negedge vertical_phase_two) begin
      if (!rst_n) begin
         rows_loaded = 0;
         rows_dumped = 0;
      end else if (dump_now === 1'b1)
         rows_dumped++;
      else if (rows_loaded < FRAME_ROWS)
         rows_loaded++;
   end
endmodule
`default_nettype wire

// ===== tb/cfrs_readout_seq_tb.sv
// Self-checking bench for the CCD frame readout sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
   $display("wrong value at %0t: got %h, expected %h", $time, a, b); end end
module cfrs_readout_seq_tb
   import cfrs_pkg::*;
();
   logic clk_sys = 0, rst_n = 0, clk_en = 1, frame_start = 0, dual_mode = 0, full_range_slow = 0, discard_line = 0;
   logic vertical_phase_one, vertical_phase_two, line_discard_gate, left_storage_phase_one, left_storage_phase_two;
   logic left_barrier_phase_one, left_barrier_phase_two, right_storage_phase_one, right_storage_phase_two;
   logic right_barrier_phase_one, right_barrier_phase_two, reset_gate_left, reset_gate_right, sample_strobe;
   logic image_valid, dark_ref_valid, frame_busy, frame_done, got_col;
   logic [10:0] row_index, pixel_index, image_col_left, image_col_right, col_l, col_r, row_i, pix_i;
   int n_fail = 0, num_checks = 0, n_smp, n_rg, n_rgr, n_img, n_drk, n_bar, rows_loaded, rows_dumped, hclk_last, c;

   always #2.5 clk_sys = ~clk_sys;

   cfrs_readout_seq uut (.clk_sys, .rst_n, .clk_en, .frame_start, .dual_mode, .full_range_slow, .discard_line,
      .vertical_phase_one, .vertical_phase_two, .line_discard_gate, .left_storage_phase_one,
      .left_storage_phase_two, .left_barrier_phase_one, .left_barrier_phase_two, .right_storage_phase_one,
      .right_storage_phase_two, .right_barrier_phase_one, .right_barrier_phase_two, .reset_gate_left,
      .reset_gate_right, .sample_strobe, .image_valid, .dark_ref_valid, .row_index, .pixel_index,
      .image_col_left, .image_col_right, .frame_busy, .frame_done);

   cfrs_sensor_model sensor (.rst_n, .vertical_phase_one, .vertical_phase_two, .line_discard_gate,
      .left_storage_phase_one, .rows_loaded, .rows_dumped, .hclk_last);

   // Per-cycle tallies of strobes and qualifiers
   always @(posedge clk_sys) begin
      if (sample_strobe === 1'b1) begin
         n_smp++;
         if (right_barrier_phase_one !== (dual_mode ? left_storage_phase_one : left_storage_phase_two))
            n_bar++;
      end
      n_rg += int'(reset_gate_left === 1'b1);
      n_rgr += int'(reset_gate_right === 1'b1);
      n_img += int'(image_valid === 1'b1);
      n_drk += int'(dark_ref_valid === 1'b1);
      if (image_valid === 1'b1 && !got_col) begin
         col_l = image_col_left;
         col_r = image_col_right;
         row_i = row_index;
         pix_i = pixel_index;
         got_col = 1'b1;
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic clr();
      n_smp = 0;
      n_rg = 0;
      n_rgr = 0;
      n_img = 0;
      n_drk = 0;
      n_bar = 0;
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: pick = vertical_phase_one;
         1: pick = vertical_phase_two;
         2: pick = left_storage_phase_one;
         default: pick = sample_strobe;
      endcase
   endfunction

   // Bounded wait for a level; a spent bound ends the run
   task automatic wait_lvl(input int s, input logic lvl, output int cyc);
      cyc = 0;
      while (pick(s) !== lvl && cyc < 20000) begin
         tick(1);
         cyc++;
      end
      if (cyc >= 20000) begin
         n_fail++;
         give_verdict();
      end
   endtask

   task automatic do_reset();
      rst_n = 0;
      tick(4);
      `CHK({vertical_phase_one, vertical_phase_two, line_discard_gate, sample_strobe, frame_busy}, 5'h00)
      rst_n = 1;
      clr();
      got_col = 1'b0;
   endtask

   task automatic start_frame(input logic dm, input logic slow, input logic disc);
      dual_mode = dm;
      full_range_slow = slow;
      discard_line = disc;
      frame_start = 1;
      tick(1);
      frame_start = 0;
      tick(1);
      `CHK(frame_busy, 1'b1)
   endtask

   task automatic t_single_line();
      start_frame(0, 0, 0);
      wait_lvl(0, 1, c);
      `CHK({left_storage_phase_one, left_barrier_phase_one, right_storage_phase_one, right_barrier_phase_two,
         left_storage_phase_two, left_barrier_phase_two, right_storage_phase_two, right_barrier_phase_one},
         8'hf0)
      wait_lvl(0, 0, c);
      `CHK(c, int'(VPULSE_CYC))
      wait_lvl(1, 0, c);
      `CHK(c, int'(VPULSE_CYC))
      clr();
      wait_lvl(2, 0, c);
      `CHK(c >= int'(HD_CYC), 1'b1)
      wait_lvl(0, 1, c);
      `CHK(n_smp, 1644)
      `CHK(n_rg, 1644)
      `CHK(n_rgr, 0)
      `CHK(n_bar, 0)
      `CHK(hclk_last, 1644)
      `CHK(rows_loaded, 1)
      $display("test single line done");
   endtask

   task automatic t_dual_rows();
      start_frame(1, 0, 0);
      wait_lvl(0, 1, c);
      `CHK({left_storage_phase_one, left_barrier_phase_one, right_storage_phase_one, right_barrier_phase_one,
         left_storage_phase_two, left_barrier_phase_two, right_storage_phase_two, right_barrier_phase_two},
         8'hf0)
      for (int r = 0; r < 7; r++) begin
         clr();
         wait_lvl(0, 0, c);
         wait_lvl(0, 1, c);
         `CHK(n_smp, 824)
         `CHK(n_rgr, 824)
         `CHK(n_bar, 0)
         `CHK(hclk_last, 824)
         `CHK(n_img, (r == 6) ? 800 : 0)
         `CHK(n_drk, (r >= 2) ? 14 : 0)
      end
      `CHK(col_l, 11'h000)
      `CHK(col_r, 11'h63f)
      `CHK(row_i, 11'd6)
      `CHK(pix_i, 11'd24)
      $display("test dual rows done");
   endtask

   task automatic t_discard_slow();
      start_frame(0, 1, 1);
      wait_lvl(0, 1, c);
      `CHK(line_discard_gate, 1'b1)
      discard_line = 0;
      dual_mode = 1;
      frame_start = 1;
      clr();
      clk_en = 0;
      tick(20);
      `CHK({vertical_phase_one, line_discard_gate}, 2'b11)
      clk_en = 1;
      wait_lvl(0, 0, c);
      `CHK(c, int'(VPULSE_CYC))
      wait_lvl(0, 1, c);
      `CHK(n_smp, 0)
      `CHK(rows_dumped, 1)
      `CHK(line_discard_gate, 1'b0)
      wait_lvl(3, 1, c);
      tick(1);
      wait_lvl(3, 1, c);
      `CHK(c + 1, int'(PIX_CYC_SLOW))
      `CHK(n_rgr, 0)
      $display("test discard and slow rate done");
   endtask

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      do_reset();
      t_single_line();
      do_reset();
      t_dual_rows();
      do_reset();
      t_discard_slow();
      do_reset();
      give_verdict();
   end
endmodule
`default_nettype wire
